// [core/vdt_pkg.sv]
package vdt_pkg;
  // Command codes
  localparam logic [7:0] CMD_RAIL_B_DROOP_FILTER_CFG = 8'hA1;
  localparam logic [7:0] CMD_AC_FILTER_RESET_DROOP_RES = 8'hA2;
  localparam logic [7:0] CMD_REVERSE_VOLTAGE_MIRROR_CFG = 8'hA3;
  localparam logic [7:0] CMD_BUS_THRESHOLD_REF_CFG = 8'hA4;
  localparam logic [7:0] CMD_BANDGAP_HIGH_UPPER_LIMIT = 8'hAC;
  localparam logic [7:0] CMD_BANDGAP_HIGH_LOWER_LIMIT = 8'hAD;
  localparam logic [7:0] CMD_BANDGAP_LOW_UPPER_LIMIT = 8'hAE;
  localparam logic [7:0] CMD_BANDGAP_LOW_LOWER_LIMIT = 8'hAF;
  localparam logic [7:0] CMD_WRITE_UNLOCK_ENTRY = 8'hB0;
  localparam logic [7:0] CMD_RAIL_A_SHED_THRESHOLD = 8'hB1;
  localparam logic [7:0] CMD_RAIL_B_SHED_THRESHOLD = 8'hB2;
  localparam logic [7:0] CMD_RAIL_A_TRIM_LOW_COUNTS = 8'hC0;
  localparam logic [7:0] CMD_RAIL_A_TRIM_HIGH_COUNTS = 8'hC1;
  localparam logic [7:0] CMD_RAIL_B_TRIM_COUNTS = 8'hC2;
  // Writable bit masks, reserved bits read zero
  localparam logic [15:0] MASK_DROOP_FILTER = 16'hFFFF;
  localparam logic [15:0] MASK_AC_RESET_RES = 16'h3FFF;
  localparam logic [15:0] MASK_MIRROR_CFG = 16'h07FB;
  localparam logic [15:0] MASK_THRESHOLD = 16'hFFFF;
  localparam logic [15:0] MASK_BG_LIMIT = 16'h03FF;
  localparam logic [15:0] MASK_UNLOCK = 16'h00FF;
  localparam logic [15:0] MASK_SHED = 16'h01FF;
  localparam logic [15:0] MASK_TRIM = 16'h7FFF;
  // Reset values
  localparam logic [15:0] RST_DROOP_FILTER = 16'h0000;
  localparam logic [15:0] RST_AC_RESET_RES = 16'h0000;
  localparam logic [15:0] RST_MIRROR_CFG = 16'h0000;
  localparam logic [15:0] RST_THRESHOLD = 16'h0000;
  localparam logic [15:0] RST_BG_UPPER = 16'h03FF;
  localparam logic [15:0] RST_BG_LOWER = 16'h0000;
  localparam logic [15:0] RST_UNLOCK = 16'h0000;
  localparam logic [15:0] RST_SHED = 16'h0000;
  localparam logic [15:0] RST_TRIM = 16'h0000;
  // Field positions
  localparam int AC_CLR_B_BIT = 15;
  localparam int AC_CLR_A_BIT = 14;
  localparam int HALF_SHORT_B_BIT = 13;
  localparam int HALF_SHORT_A_BIT = 6;
  localparam int FLOAT_B_BIT = 10;
  localparam int FLOAT_A_BIT = 9;
  localparam int HEADROOM_B_BIT = 8;
  localparam int HEADROOM_A_BIT = 5;
  localparam int REF_HIGH_BIT = 15;
  localparam int HYST_BIT = 14;
  localparam int NEG_SLOW_BIT = 7;
  localparam int POS_SLOW_BIT = 3;
  // Analog scaling
  localparam logic [11:0] FAST_TAU_NS = 12'h014;
  localparam logic [11:0] SLOW_TAU_NS = 12'hFA0;
  localparam logic [7:0] RVP_HIGH_MV = 8'hA0;
  localparam logic [7:0] RVP_LOW_MV = 8'h50;
  localparam logic [8:0] REF_HIGH_MV = 9'h140;
  localparam logic [8:0] REF_LOW_MV = 9'h0F0;
  localparam logic [6:0] TRIM_STEP_HIGH_X10 = 7'h64;
  localparam logic [6:0] TRIM_STEP_LOW_X10 = 7'h4B;
  localparam logic [8:0] HEADROOM_LOW_MV = 9'h0FA;
  localparam logic [5:0] FB_OHM_STEP = 6'h32;
  localparam logic [6:0] AC_OHM_STEP = 7'h64;
  localparam logic [10:0] PROG_FULL_MV = 11'h708;
  localparam logic [10:0] VIH_3V3_MV = 11'h708;
  localparam logic [10:0] VIL_3V3_MV = 11'h3F2;
  localparam logic [10:0] VIH_1V8_MV = 11'h460;
  localparam logic [10:0] VIL_1V8_MV = 11'h230;
  localparam logic [10:0] VIH_1V2_MV = 11'h314;
  localparam logic [10:0] VIL_1V2_MV = 11'h1C2;
endpackage

// [core/vdt_regs.sv]
`timescale 1ns/1ps
module vdt_regs
  import vdt_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic cmd_wr_in,
  input wire logic cmd_rd_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic [15:0] cmd_wdata_in,
  input wire logic [7:0] stored_password_in,
  input wire logic self_check_en_in,
  input wire logic [9:0] ref_check_high_level_in,
  input wire logic [9:0] ref_check_low_level_in,
  input wire logic [1:0] stage_low_power_in,
  input wire logic [1:0] stage_enable_in,
  input wire logic [7:0] rail_a_current_in,
  input wire logic [7:0] rail_b_current_in,
  input wire logic [2:0] rail_a_phase_count_in,
  input wire logic [2:0] rail_b_phase_count_in,
  output logic [15:0] cmd_rdata_out,
  output logic cmd_rvalid_out,
  output logic write_refused_out,
  output logic reference_check_fault_out,
  output logic rail_a_ac_filter_clear_out,
  output logic rail_b_ac_filter_clear_out,
  output logic [7:0] rail_a_rvp_mv_out,
  output logic [7:0] rail_b_rvp_mv_out,
  output logic [2:0] rail_a_mirror_ratio_out,
  output logic [2:0] rail_b_mirror_ratio_out,
  output logic [8:0] rail_a_headroom_mv_out,
  output logic [8:0] rail_b_headroom_mv_out,
  output logic rail_a_stage_enable_out,
  output logic rail_a_stage_enable_oe_out,
  output logic rail_b_stage_enable_out,
  output logic rail_b_stage_enable_oe_out,
  output logic [10:0] bus_vih_mv_out,
  output logic [10:0] bus_vil_mv_out,
  output logic [8:0] comparator_ref_mv_out,
  output logic [6:0] trim_step_x10_mv_out,
  output logic comparator_hysteresis_on_out,
  output logic [14:0] rail_b_neg_filter_time_out,
  output logic [14:0] rail_b_pos_filter_time_out,
  output logic [1:0] single_phase_out,
  output logic [11:0] rail_a_fb_droop_res_out,
  output logic [11:0] rail_b_fb_droop_res_out,
  output logic [10:0] rail_b_ac_droop_res_out,
  output logic [3:0] rail_b_droop_ctrl_out,
  output logic rail_a_half_string_short_out,
  output logic rail_b_half_string_short_out,
  output logic [4:0] rail_a_trim_out,
  output logic [4:0] rail_b_trim_out
);

  // ----------------------------------------------------------
  // Storage and write gate
  // ----------------------------------------------------------
  logic [15:0] droop_filter_q;
  logic [15:0] ac_reset_res_q;
  logic [15:0] mirror_cfg_q;
  logic [15:0] threshold_q;
  logic [15:0] bg_h_max_q;
  logic [15:0] bg_h_min_q;
  logic [15:0] bg_l_max_q;
  logic [15:0] bg_l_min_q;
  logic [15:0] unlock_q;
  logic [15:0] shed_q [2];
  logic [15:0] trim_a_low_q;
  logic [15:0] trim_a_high_q;
  logic [15:0] trim_b_q;
  logic unlocked;
  logic wr_ok;
  logic wr_locked;

  // Entry register stays writable so a locked part can be opened
  assign unlocked = (unlock_q[7:0] == stored_password_in);
  assign wr_ok = cmd_wr_in &&
                 (unlocked || cmd_code_in == CMD_WRITE_UNLOCK_ENTRY);
  assign wr_locked = cmd_wr_in && !wr_ok;

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      droop_filter_q <= RST_DROOP_FILTER;
      ac_reset_res_q <= RST_AC_RESET_RES;
      mirror_cfg_q <= RST_MIRROR_CFG;
      threshold_q <= RST_THRESHOLD;
      bg_h_max_q <= RST_BG_UPPER;
      bg_h_min_q <= RST_BG_LOWER;
      bg_l_max_q <= RST_BG_UPPER;
      bg_l_min_q <= RST_BG_LOWER;
      unlock_q <= RST_UNLOCK;
      shed_q[0] <= RST_SHED;
      shed_q[1] <= RST_SHED;
      trim_a_low_q <= RST_TRIM;
      trim_a_high_q <= RST_TRIM;
      trim_b_q <= RST_TRIM;
    end else if (wr_ok) begin
      unique case (cmd_code_in)
        CMD_RAIL_B_DROOP_FILTER_CFG:
          droop_filter_q <= cmd_wdata_in & MASK_DROOP_FILTER;
        CMD_AC_FILTER_RESET_DROOP_RES:
          ac_reset_res_q <= cmd_wdata_in & MASK_AC_RESET_RES;
        CMD_REVERSE_VOLTAGE_MIRROR_CFG:
          mirror_cfg_q <= cmd_wdata_in & MASK_MIRROR_CFG;
        CMD_BUS_THRESHOLD_REF_CFG:
          threshold_q <= cmd_wdata_in & MASK_THRESHOLD;
        CMD_BANDGAP_HIGH_UPPER_LIMIT:
          bg_h_max_q <= cmd_wdata_in & MASK_BG_LIMIT;
        CMD_BANDGAP_HIGH_LOWER_LIMIT:
          bg_h_min_q <= cmd_wdata_in & MASK_BG_LIMIT;
        CMD_BANDGAP_LOW_UPPER_LIMIT:
          bg_l_max_q <= cmd_wdata_in & MASK_BG_LIMIT;
        CMD_BANDGAP_LOW_LOWER_LIMIT:
          bg_l_min_q <= cmd_wdata_in & MASK_BG_LIMIT;
        CMD_WRITE_UNLOCK_ENTRY:
          unlock_q <= cmd_wdata_in & MASK_UNLOCK;
        CMD_RAIL_A_SHED_THRESHOLD:
          shed_q[0] <= cmd_wdata_in & MASK_SHED;
        CMD_RAIL_B_SHED_THRESHOLD:
          shed_q[1] <= cmd_wdata_in & MASK_SHED;
        CMD_RAIL_A_TRIM_LOW_COUNTS:
          trim_a_low_q <= cmd_wdata_in & MASK_TRIM;
        CMD_RAIL_A_TRIM_HIGH_COUNTS:
          trim_a_high_q <= cmd_wdata_in & MASK_TRIM;
        CMD_RAIL_B_TRIM_COUNTS:
          trim_b_q <= cmd_wdata_in & MASK_TRIM;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // Read port and refusal flag
  // ----------------------------------------------------------
  logic [15:0] rdata_d;

  always_comb begin
    unique case (cmd_code_in)
      CMD_RAIL_B_DROOP_FILTER_CFG: rdata_d = droop_filter_q;
      CMD_AC_FILTER_RESET_DROOP_RES: rdata_d = ac_reset_res_q;
      CMD_REVERSE_VOLTAGE_MIRROR_CFG: rdata_d = mirror_cfg_q;
      CMD_BUS_THRESHOLD_REF_CFG: rdata_d = threshold_q;
      CMD_BANDGAP_HIGH_UPPER_LIMIT: rdata_d = bg_h_max_q;
      CMD_BANDGAP_HIGH_LOWER_LIMIT: rdata_d = bg_h_min_q;
      CMD_BANDGAP_LOW_UPPER_LIMIT: rdata_d = bg_l_max_q;
      CMD_BANDGAP_LOW_LOWER_LIMIT: rdata_d = bg_l_min_q;
      CMD_WRITE_UNLOCK_ENTRY: rdata_d = unlock_q;
      CMD_RAIL_A_SHED_THRESHOLD: rdata_d = shed_q[0];
      CMD_RAIL_B_SHED_THRESHOLD: rdata_d = shed_q[1];
      CMD_RAIL_A_TRIM_LOW_COUNTS: rdata_d = trim_a_low_q;
      CMD_RAIL_A_TRIM_HIGH_COUNTS: rdata_d = trim_a_high_q;
      CMD_RAIL_B_TRIM_COUNTS: rdata_d = trim_b_q;
      default: rdata_d = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      cmd_rdata_out <= 16'h0000;
      cmd_rvalid_out <= 1'b0;
    end else begin
      cmd_rvalid_out <= cmd_rd_in;
      if (cmd_rd_in) begin
        cmd_rdata_out <= rdata_d;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      write_refused_out <= 1'b0;
    end else begin
      write_refused_out <= wr_locked;
    end
  end

  // ----------------------------------------------------------
  // AC filter clear strobes
  // ----------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      rail_a_ac_filter_clear_out <= 1'b0;
      rail_b_ac_filter_clear_out <= 1'b0;
    end else begin
      rail_b_ac_filter_clear_out <= wr_ok &&
        cmd_code_in == CMD_AC_FILTER_RESET_DROOP_RES &&
        cmd_wdata_in[AC_CLR_B_BIT];
      rail_a_ac_filter_clear_out <= wr_ok &&
        cmd_code_in == CMD_AC_FILTER_RESET_DROOP_RES &&
        cmd_wdata_in[AC_CLR_A_BIT];
    end
  end

  // ----------------------------------------------------------
  // Bandgap self-check
  // ----------------------------------------------------------
  logic bg_over;
  logic bg_under;

  assign bg_over = ref_check_high_level_in > bg_h_max_q[9:0] ||
                   ref_check_low_level_in > bg_l_max_q[9:0];
  assign bg_under = ref_check_high_level_in < bg_h_min_q[9:0] ||
                    ref_check_low_level_in < bg_l_min_q[9:0];

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      reference_check_fault_out <= 1'b0;
    end else begin
      reference_check_fault_out <= self_check_en_in &&
                                   (bg_over || bg_under);
    end
  end

  // ----------------------------------------------------------
  // Bus input thresholds
  // ----------------------------------------------------------
  function automatic logic [10:0] prog_mv(input logic [3:0] code);
    logic [15:0] prod;
    prod = ({11'h000, 5'(code) + 5'h01}) * {5'h00, PROG_FULL_MV};
    return prod[14:4];
  endfunction

  logic [10:0] vih_d;
  logic [10:0] vil_d;

  always_comb begin
    unique case (threshold_q[9:8])
      2'h0: begin
        vih_d = VIH_3V3_MV;
        vil_d = VIL_3V3_MV;
      end
      2'h1: begin
        vih_d = VIH_1V8_MV;
        vil_d = VIL_1V8_MV;
      end
      2'h2: begin
        vih_d = VIH_1V2_MV;
        vil_d = VIL_1V2_MV;
      end
      2'h3: begin
        vih_d = prog_mv(threshold_q[7:4]);
        vil_d = prog_mv(threshold_q[3:0]);
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      bus_vih_mv_out <= VIH_3V3_MV;
      bus_vil_mv_out <= VIL_3V3_MV;
      comparator_ref_mv_out <= REF_LOW_MV;
      trim_step_x10_mv_out <= TRIM_STEP_LOW_X10;
      comparator_hysteresis_on_out <= 1'b0;
    end else begin
      bus_vih_mv_out <= vih_d;
      bus_vil_mv_out <= vil_d;
      comparator_ref_mv_out <= threshold_q[REF_HIGH_BIT] ?
                               REF_HIGH_MV : REF_LOW_MV;
      trim_step_x10_mv_out <= threshold_q[REF_HIGH_BIT] ?
                              TRIM_STEP_HIGH_X10 :
                              TRIM_STEP_LOW_X10;
      comparator_hysteresis_on_out <= threshold_q[HYST_BIT];
    end
  end

  // ----------------------------------------------------------
  // Droop, filter and protection settings
  // ----------------------------------------------------------
  function automatic logic [14:0] tau_ns(input logic slow,
                                         input logic [2:0] field);
    logic [2:0] mult;
    mult = 3'h7 - field;
    return {3'h0, slow ? SLOW_TAU_NS : FAST_TAU_NS} * {12'h000, mult};
  endfunction

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      rail_b_neg_filter_time_out <= 15'h0000;
      rail_b_pos_filter_time_out <= 15'h0000;
      rail_b_ac_droop_res_out <= 11'h000;
      rail_b_droop_ctrl_out <= 4'h0;
      rail_a_fb_droop_res_out <= 12'h000;
      rail_b_fb_droop_res_out <= 12'h000;
      rail_a_half_string_short_out <= 1'b0;
      rail_b_half_string_short_out <= 1'b0;
    end else begin
      rail_b_neg_filter_time_out <= tau_ns(droop_filter_q[NEG_SLOW_BIT],
                                           droop_filter_q[6:4]);
      rail_b_pos_filter_time_out <= tau_ns(droop_filter_q[POS_SLOW_BIT],
                                           droop_filter_q[2:0]);
      rail_b_ac_droop_res_out <= {7'h00, droop_filter_q[11:8]} *
                                 {4'h0, AC_OHM_STEP};
      rail_b_droop_ctrl_out <= droop_filter_q[15:12];
      rail_b_fb_droop_res_out <= {6'h00, ac_reset_res_q[12:7]} *
                                 {6'h00, FB_OHM_STEP};
      rail_a_fb_droop_res_out <= {6'h00, ac_reset_res_q[5:0]} *
                                 {6'h00, FB_OHM_STEP};
      rail_b_half_string_short_out <=
        ac_reset_res_q[HALF_SHORT_B_BIT];
      rail_a_half_string_short_out <=
        ac_reset_res_q[HALF_SHORT_A_BIT];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      rail_a_rvp_mv_out <= RVP_LOW_MV;
      rail_b_rvp_mv_out <= RVP_LOW_MV;
      rail_a_mirror_ratio_out <= 3'h4;
      rail_b_mirror_ratio_out <= 3'h4;
      rail_a_headroom_mv_out <= 9'h000;
      rail_b_headroom_mv_out <= 9'h000;
    end else begin
      rail_b_rvp_mv_out <= mirror_cfg_q[1] ? RVP_HIGH_MV : RVP_LOW_MV;
      rail_a_rvp_mv_out <= mirror_cfg_q[0] ? RVP_HIGH_MV : RVP_LOW_MV;
      // Ratio is 1 / 2**n: code 0 gives 1/16, code 3 gives 1/2
      rail_b_mirror_ratio_out <= 3'h4 - {1'b0, mirror_cfg_q[7:6]};
      rail_a_mirror_ratio_out <= 3'h4 - {1'b0, mirror_cfg_q[4:3]};
      rail_b_headroom_mv_out <= mirror_cfg_q[HEADROOM_B_BIT] ?
                                HEADROOM_LOW_MV : 9'h000;
      rail_a_headroom_mv_out <= mirror_cfg_q[HEADROOM_A_BIT] ?
                                HEADROOM_LOW_MV : 9'h000;
    end
  end

  // ----------------------------------------------------------
  // Power-stage enable pins
  // ----------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      rail_a_stage_enable_out <= 1'b0;
      rail_b_stage_enable_out <= 1'b0;
      rail_a_stage_enable_oe_out <= 1'b1;
      rail_b_stage_enable_oe_out <= 1'b1;
    end else begin
      rail_a_stage_enable_out <= stage_enable_in[0];
      rail_b_stage_enable_out <= stage_enable_in[1];
      rail_a_stage_enable_oe_out <= !(mirror_cfg_q[FLOAT_A_BIT] &&
                                      stage_low_power_in[0]);
      rail_b_stage_enable_oe_out <= !(mirror_cfg_q[FLOAT_B_BIT] &&
                                      stage_low_power_in[1]);
    end
  end

  // ----------------------------------------------------------
  // Phase shedding, one per rail
  // ----------------------------------------------------------
  logic [7:0] rail_current [2];
  assign rail_current[0] = rail_a_current_in;
  assign rail_current[1] = rail_b_current_in;

  for (genvar r = 0; r < 2; r++) begin : g_shed
    logic [7:0] return_level;
    assign return_level = {3'h0, shed_q[r][8:4]} +
                          {4'h0, shed_q[r][3:0]};
    always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
        single_phase_out[r] <= 1'b0;
      end else if (!single_phase_out[r]) begin
        single_phase_out[r] <= rail_current[r] <
                               {3'h0, shed_q[r][8:4]};
      end else begin
        single_phase_out[r] <= rail_current[r] < return_level;
      end
    end
  end

  // ----------------------------------------------------------
  // Output trim by active phase count
  // ----------------------------------------------------------
  logic [4:0] trim_a_d;
  logic [4:0] trim_b_d;

  always_comb begin
    unique case (rail_a_phase_count_in)
      3'h1: trim_a_d = trim_a_low_q[4:0];
      3'h2: trim_a_d = trim_a_low_q[9:5];
      3'h3: trim_a_d = trim_a_low_q[14:10];
      3'h4: trim_a_d = trim_a_high_q[4:0];
      3'h5: trim_a_d = trim_a_high_q[9:5];
      3'h6: trim_a_d = trim_a_high_q[14:10];
      default: trim_a_d = 5'h00;
    endcase
    unique case (rail_b_phase_count_in)
      3'h1: trim_b_d = trim_b_q[4:0];
      3'h2: trim_b_d = trim_b_q[9:5];
      3'h3: trim_b_d = trim_b_q[14:10];
      default: trim_b_d = 5'h00;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      rail_a_trim_out <= 5'h00;
      rail_b_trim_out <= 5'h00;
    end else begin
      rail_a_trim_out <= trim_a_d;
      rail_b_trim_out <= trim_b_d;
    end
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  sequence s_open_wr(logic [7:0] code);
    wr_ok && cmd_code_in == code ##1 !cmd_wr_in;
  endsequence

  chk_locked_write_kept: assert property (
    wr_locked && cmd_code_in == CMD_BUS_THRESHOLD_REF_CFG
    |=> threshold_q == $past(threshold_q) && write_refused_out)
    else $error("locked write changed a register");

  chk_bg_over_fault: assert property (
    self_check_en_in && ref_check_high_level_in > bg_h_max_q[9:0]
    |=> reference_check_fault_out)
    else $error("bandgap over limit not flagged");

  chk_bg_under_fault: assert property (
    self_check_en_in && ref_check_high_level_in < bg_h_min_q[9:0]
    |=> reference_check_fault_out)
    else $error("bandgap under limit not flagged");

  chk_ac_clear_pulse: assert property (
    wr_ok && cmd_code_in == CMD_AC_FILTER_RESET_DROOP_RES &&
    cmd_wdata_in[AC_CLR_B_BIT] ##1 !cmd_wr_in
    |-> rail_b_ac_filter_clear_out ##1 !rail_b_ac_filter_clear_out)
    else $error("AC filter clear not a single pulse");

  chk_rvp_select: assert property (
    s_open_wr(CMD_REVERSE_VOLTAGE_MIRROR_CFG) |=>
    rail_b_rvp_mv_out == ($past(cmd_wdata_in[1], 2) ? 8'hA0 : 8'h50))
    else $error("reverse threshold wrong");

  chk_float_stage: assert property (
    mirror_cfg_q[FLOAT_A_BIT] && stage_low_power_in[0]
    |=> !rail_a_stage_enable_oe_out)
    else $error("stage enable not floated");

  chk_prog_threshold: assert property (
    s_open_wr(CMD_BUS_THRESHOLD_REF_CFG) ##0
    $past(cmd_wdata_in[9:8]) == 2'h3 && $past(cmd_wdata_in[3:0]) == 4'hF
    |=> bus_vil_mv_out == 11'h708)
    else $error("programmable threshold wrong");

  chk_hysteresis_bit: assert property (
    s_open_wr(CMD_BUS_THRESHOLD_REF_CFG) |=>
    comparator_hysteresis_on_out == $past(cmd_wdata_in[HYST_BIT], 2))
    else $error("hysteresis enable mismatch");

  chk_shed_hold: assert property (
    single_phase_out[0] && rail_a_current_in < g_shed[0].return_level
    |=> single_phase_out[0])
    else $error("left single phase inside hysteresis");

endmodule // vdt_regs

// [dv/vdt_host.sv]
`timescale 1ns/1ps
module vdt_host (
  input wire logic clk_in,
  input wire logic [15:0] rdata_in,
  input wire logic rvalid_in,
  output logic wr_out = 1'b0,
  output logic rd_out = 1'b0,
  output logic [7:0] code_out = 8'h00,
  output logic [15:0] wdata_out = 16'h0000
);
  // ----------
  // Host bus
  // ----------
  task wr(input logic [7:0] c, input logic [15:0] d);
    @(negedge clk_in) {wr_out, code_out, wdata_out} = {1'b1, c, d};
    @(negedge clk_in) {wr_out, wdata_out} = {1'b0, ~d};
  endtask
  task rd(input logic [7:0] c, output logic [15:0] d);
    @(negedge clk_in) {rd_out, code_out} = {1'b1, c};
    @(negedge clk_in) rd_out = 1'b0;
    // No valid strobe: hand back corrupted data
    d = rvalid_in ? rdata_in : ~rdata_in;
  endtask
endmodule // vdt_host

// [dv/tb.sv]
`timescale 1ns/1ps
module tb;
  import vdt_pkg::*;
  localparam logic [7:0] CS [14] = '{8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hAC,
    8'hAD, 8'hAE, 8'hAF, 8'hB0, 8'hB1, 8'hB2, 8'hC0, 8'hC1, 8'hC2};
  localparam logic [9:0] LV [5] = '{10'h180, 10'h201, 10'h200, 10'h0FF,
    10'h100};
  localparam logic [7:0] IA [5] = '{8'd13, 8'd9, 8'd12, 8'd13, 8'd10};
  localparam logic [4:0] SP = 5'b00110;
  logic clk = 1'b0, rst = 1'b1, sc = 1'b0, wr, rd, rv, rf, flt, ca, oe;
  logic cbc, hy, hs;
  logic [7:0] pw = 8'h00, ia = 8'h00, cd, rvp;
  logic [9:0] lh = 10'h180;
  logic [2:0] pa = 3'h1, mir;
  logic [1:0] sp;
  logic [15:0] wd, rdat, d, x;
  logic [10:0] vih, vil, acr;
  logic [11:0] fbr;
  logic [8:0] cref, hr;
  logic [6:0] stp;
  logic [3:0] dc;
  logic [14:0] tau, pt;
  logic [4:0] trm;
  int n_mismatch = 0, total_checks = 0;
  // ----------
  // Wiring
  // ----------
  vdt_host h (.clk_in(clk), .rdata_in(rdat), .rvalid_in(rv), .wr_out(wr),
    .rd_out(rd), .code_out(cd), .wdata_out(wd));
  vdt_regs DUT (.sys_clk_in(clk), .reset_in(rst), .cmd_wr_in(wr),
    .cmd_rd_in(rd), .cmd_code_in(cd), .cmd_wdata_in(wd),
    .stored_password_in(pw), .self_check_en_in(sc),
    .ref_check_high_level_in(lh), .ref_check_low_level_in(10'h180),
    .stage_low_power_in(2'h1), .stage_enable_in(2'h3),
    .rail_a_current_in(ia), .rail_b_current_in(8'h00),
    .rail_a_phase_count_in(pa), .rail_b_phase_count_in(3'h1),
    .cmd_rdata_out(rdat), .cmd_rvalid_out(rv), .write_refused_out(rf),
    .reference_check_fault_out(flt), .rail_a_ac_filter_clear_out(ca),
    .rail_b_ac_filter_clear_out(cbc), .rail_a_rvp_mv_out(),
    .rail_b_rvp_mv_out(rvp), .rail_a_mirror_ratio_out(mir),
    .rail_b_mirror_ratio_out(), .rail_a_headroom_mv_out(hr),
    .rail_b_headroom_mv_out(), .rail_a_stage_enable_out(),
    .rail_a_stage_enable_oe_out(oe), .rail_b_stage_enable_out(),
    .rail_b_stage_enable_oe_out(), .bus_vih_mv_out(vih),
    .bus_vil_mv_out(vil), .comparator_ref_mv_out(cref),
    .trim_step_x10_mv_out(stp), .comparator_hysteresis_on_out(hy),
    .rail_b_neg_filter_time_out(tau), .rail_b_pos_filter_time_out(pt),
    .single_phase_out(sp), .rail_a_fb_droop_res_out(),
    .rail_b_fb_droop_res_out(fbr), .rail_b_ac_droop_res_out(acr),
    .rail_b_droop_ctrl_out(dc), .rail_a_half_string_short_out(),
    .rail_b_half_string_short_out(hs), .rail_a_trim_out(trm),
    .rail_b_trim_out());
  initial forever #2.5 clk = ~clk;
  function automatic logic [15:0] msk(input logic [7:0] c);
    case (c)
      8'hA2: msk = 16'h3FFF;
      8'hA3: msk = 16'h07FB;
      8'hB0: msk = 16'h00FF;
      8'hB1, 8'hB2: msk = 16'h01FF;
      8'hC0, 8'hC1, 8'hC2: msk = 16'h7FFF;
      default: msk = c[3] ? 16'h03FF : 16'hFFFF;
    endcase
  endfunction
  task chk(input string n, input logic [15:0] e, g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task st;
    repeat (2) @(negedge clk);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #20000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    x = 16'($urandom(78));
    repeat (2) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    foreach (CS[i]) begin
      h.rd(CS[i], d);
      chk("reset", CS[i][3] & ~CS[i][0] ? 16'h03FF : 16'h0, d);
    end
    x = 16'($urandom);
    h.wr(8'hB0, x);
    pw = x[7:0];
    foreach (CS[i]) begin
      x = 16'($urandom);
      if (CS[i] != 8'hB0) h.wr(CS[i], x);
      else x = {8'h00, pw};
      h.rd(CS[i], d);
      chk("readback", x & msk(CS[i]), d);
    end
    h.rd(8'hA4, x);
    pw = ~pw;
    h.wr(8'hA4, ~x);
    chk("refused", 1, rf);
    h.rd(8'hA4, d);
    chk("locked", x, d);
    h.wr(8'hB0, {8'h00, pw});
    h.wr(8'hA4, 16'hC3AF);
    st();
    chk("vih", 11'd1237, vih);
    chk("vil", 11'd1800, vil);
    chk("ref", 9'd320, cref);
    chk("step", 7'd100, stp);
    chk("hyst", 1, hy);
    h.wr(8'hA4, 16'h0200);
    st();
    chk("vih", 11'd788, vih);
    chk("vil", 11'd450, vil);
    chk("ref", 9'd240, cref);
    chk("step", 7'd75, stp);
    chk("hyst", 0, hy);
    repeat (6) begin
      x = 16'($urandom);
      pa = 3'($urandom_range(6, 1));
      h.wr(8'hA3, x);
      h.wr(8'hA1, x);
      h.wr(8'hA2, x);
      h.wr(8'hC0, x);
      h.wr(8'hC1, x);
      st();
      chk("rvp", x[1] ? 8'd160 : 8'd80, rvp);
      chk("mirror", 3'd4 - x[4:3], mir);
      chk("float", !x[9], oe);
      chk("tau", (x[7] ? 4000 : 20) * (7 - x[6:4]), tau);
      chk("ptau", (x[3] ? 4000 : 20) * (7 - x[2:0]), pt);
      chk("acres", x[11:8] * 100, acr);
      chk("dctl", x[15:12], dc);
      chk("fbres", x[12:7] * 50, fbr);
      chk("short", x[13], hs);
      chk("head", x[5] ? 250 : 0, hr);
      chk("trim", 5'(x >> (5 * ((pa - 1) % 3))), trm);
    end
    h.wr(8'hA2, 16'hC000);
    chk("clear", 1, ca);
    chk("clear_b", 1, cbc);
    h.wr(8'hA2, 16'h0000);
    chk("clear", 0, ca);
    chk("clear_b", 0, cbc);
    h.wr(8'hAC, 16'h0200);
    h.wr(8'hAD, 16'h0100);
    h.wr(8'hAE, 16'h03FF);
    h.wr(8'hAF, 16'h0000);
    sc = 1'b1;
    foreach (LV[i]) begin
      lh = LV[i];
      st();
      chk("fault", LV[i] > 10'h200 || LV[i] < 10'h100, flt);
    end
    h.wr(8'hB1, 16'h00A3);
    foreach (IA[i]) begin
      ia = IA[i];
      st();
      chk("shed", SP[i], sp[0]);
    end
    tally_and_finish();
  end
endmodule // tb
